// ### hw/sjcd_image_mem.sv
`timescale 1ns/100ps
`include "sjcd_map.svh"

// ************************************************
// image store with registered read port
// ************************************************
module sjcd_image_mem #(
	parameter int unsigned DEPTH = `SJCD_WORDS,
	parameter int unsigned WIDTH = `SJCD_WORD_W,
	localparam int unsigned AW   = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// write port
	input  wire logic             we_in,
	input  wire logic [AW-1:0]    waddr_in,
	input  wire logic [WIDTH-1:0] wdata_in,
	// read port
	input  wire logic [AW-1:0]    raddr_in,
	output logic      [WIDTH-1:0] rdata_out
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH < 2) begin : g_bad_depth
		$error("image depth too small");
	end

	// write side
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	// read data leaves from a register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= mem[raddr_in];
		end
	end
endmodule // sjcd_image_mem

// ### hw/sjcd_map.svh
`ifndef SJCD_MAP_SVH
`define SJCD_MAP_SVH

// ************************************************
// image geometry
// ************************************************
`define SJCD_WORDS      64
`define SJCD_WORD_W     16

// ************************************************
// byte offsets of the soft jumper area
// ************************************************
`define SJCD_CTRL_LOW   8'h30
`define SJCD_CTRL_HIGH  8'h31
`define SJCD_PULLUP     8'h32
`define SJCD_FACT_PRI   8'h33
`define SJCD_FACT_BKA   8'h34
`define SJCD_FACT_BKB   8'h35
`define SJCD_SOFT_ID    8'h36
`define SJCD_HEADS      8'h37
`define SJCD_CUST       8'h38
`define SJCD_SPIN_DLY   8'h39
`define SJCD_AUTO_INH   8'h3a
`define SJCD_CSUM       8'h3b
`define SJCD_AREA_LEN   12

// ************************************************
// field positions inside their bytes
// ************************************************
`define SJCD_WS_BIT     0
`define SJCD_DPC_BIT    1
`define SJCD_SS_BIT     2
`define SJCD_DLY_BIT    3
`define SJCD_ACK_BIT    0
`define SJCD_DAPU_BIT   4
`define SJCD_RAPU_BIT   5
`define SJCD_FACT_BIT   0
`define SJCD_SOFT_ID_SELECT_BIT   3

// ************************************************
// serial read frame and timing
// ************************************************
`define SJCD_RD_CMD     3'h6
`define SJCD_ADDR_LAST  8
`define SJCD_LAST_BIT   24
`define SJCD_SK_HALF    5
`define SJCD_CLK_NS     100
`define SJCD_DLY_UNIT_MS 10

// ************************************************
// fallback values
// ************************************************
`define SJCD_DEF_HEADS  8'h01

`endif

// ### hw/sjcd_pkg.sv
package sjcd_pkg;

	// ************************************************
	// types shared by the loader
	// ************************************************
	typedef logic [7:0] sjcd_byte_t;

	typedef enum logic [2:0] {
		ST_LOAD_REQ  = 3'h0,
		ST_LOAD_WAIT = 3'h1,
		ST_CHECK     = 3'h3,
		ST_WAIT_SPIN = 3'h2,
		ST_SPIN_DLY  = 3'h6,
		ST_RUN       = 3'h4
	} sjcd_state_e;

	// pins toward the serial configuration memory
	typedef struct packed {
		logic cs;
		logic sk;
		logic di;
	} sjcd_ee_pins_s;

	// decoded working settings
	typedef struct packed {
		logic       wait_spin_enable;
		logic       parity_check_disable;
		logic       self_seek_enable;
		logic       delayed_spinup_enable;
		logic       ack_glitch_filter_enable;
		logic       data_active_negation;
		logic       req_active_negation;
		logic       factory_config_mode;
		logic       soft_id_select;
		logic [2:0] soft_bus_id;
		logic [7:0] heads_per_cylinder;
		logic [2:0] customer_profile;
		logic [7:0] spinup_delay_count;
		logic [7:0] auto_config_inhibit;
	} sjcd_cfg_s;

endpackage

// ### hw/sjcd_serial_rd.sv
`timescale 1ns/100ps
`include "sjcd_map.svh"

// ************************************************
// one-word read from the serial memory
// ************************************************
module sjcd_serial_rd #(
	parameter int unsigned SK_HALF = `SJCD_SK_HALF
) (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	// request and answer
	input  wire logic                  start_in,
	input  wire logic [5:0]            addr_in,
	output logic                       done_out,
	output logic [15:0]                data_out,
	// memory pins
	output sjcd_pkg::sjcd_ee_pins_s    ee_out,
	input  wire logic                  ee_do_in
);
	import sjcd_pkg::*;

	localparam logic [3:0] DIV_LAST = 4'(SK_HALF - 1);

	typedef struct packed {
		logic          busy;
		logic          done;
		logic [3:0]    div;
		logic [4:0]    bitn;
		logic [8:0]    cmd;
		logic [15:0]   shin;
		logic          do_meta;
		logic          do_sync;
		sjcd_ee_pins_s ee;
	} sjcd_ser_s;

	sjcd_ser_s s_q;
	sjcd_ser_s s_d;

	if (SK_HALF < 3 || SK_HALF > 16) begin : g_bad_half
		$error("serial half period out of range");
	end

	// frame: start, read opcode, address, then dummy and 16 data bits
	always_comb begin
		s_d         = s_q;
		s_d.do_meta = ee_do_in;
		s_d.do_sync = s_q.do_meta;
		s_d.done    = 1'b0;
		if (!s_q.busy) begin
			if (start_in) begin
				s_d.busy  = 1'b1;
				s_d.div   = '0;
				s_d.bitn  = '0;
				s_d.cmd   = {`SJCD_RD_CMD, addr_in};
				s_d.ee.cs = 1'b1;
				s_d.ee.sk = 1'b0;
				s_d.ee.di = s_d.cmd[8];
			end
		end else if (s_q.div == DIV_LAST) begin
			s_d.div = '0;
			if (!s_q.ee.sk) begin
				s_d.ee.sk = 1'b1; // memory takes di here
			end else begin
				s_d.ee.sk = 1'b0;
				// data sampled on the falling half, after the memory drove it
				if (s_q.bitn >= 5'(`SJCD_ADDR_LAST)) begin
					s_d.shin = {s_q.shin[14:0], s_q.do_sync};
				end
				if (s_q.bitn == 5'(`SJCD_LAST_BIT)) begin
					s_d.busy  = 1'b0;
					s_d.done  = 1'b1;
					s_d.ee.cs = 1'b0;
					s_d.ee.di = 1'b0;
				end else begin
					s_d.bitn  = s_q.bitn + 5'h01;
					s_d.cmd   = {s_q.cmd[7:0], 1'b0};
					s_d.ee.di = s_d.cmd[8];
				end
			end
		end else begin
			s_d.div = s_q.div + 4'h1;
		end
	end

	// state register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done_out = s_q.done;
	assign data_out = s_q.shin;
	assign ee_out   = s_q.ee;
endmodule // sjcd_serial_rd

// ### hw/sjcd_top.sv
`timescale 1ns/100ps
`include "sjcd_map.svh"

// What this block does
// - read the whole 64-word, 16-bit image from the serial memory
// - control bit 0 set means hold the spindle until a spin command
// - control bit 1 set disables host bus parity checking
// - control bit 2 set enables self-seek
// - control bit 3 set postpones spindle start by the delay count
// - delay count sits in byte 57, 10 ms per step, used only when delayed
// - control bits 4 to 7 are obsolete, written zero and ignored here
// - control bit 8 enables the ACK glitch filter, not above 10 Mbyte/s
// - pull-up byte bit 4 drives data lines high on negation
// - pull-up byte bit 5 drives REQ on negation; slew bits stay unused
// - factory bit set skips bus start-up, so no bus commands answered
// - bytes 52 and 53 back up factory byte and are cross-checked
// - soft ID select clear takes bus ID from the board jumpers
// - soft ID select set takes bus ID from the 3-bit soft field
// - drive type byte gives heads per cylinder for geometry
module sjcd_top #(
	parameter int unsigned DLY_UNIT_CYC = (`SJCD_DLY_UNIT_MS * 1000000) / `SJCD_CLK_NS,
	parameter int unsigned SK_HALF      = `SJCD_SK_HALF
) (
	// clock and reset
	input  wire logic                  REF_CLK_IN,
	input  wire logic                  RST_IN,
	// serial configuration memory
	output sjcd_pkg::sjcd_ee_pins_s    EE_PINS_OUT,
	input  wire logic                  EE_DO_IN,
	// board jumpers
	input  wire logic [2:0]            JUMPER_ID_IN,
	// firmware controls
	input  wire logic                  SPIN_CMD_IN,
	input  wire logic                  RELOAD_IN,
	// image readback
	input  wire logic [5:0]            IMG_ADDR_IN,
	output logic      [15:0]           IMG_DATA_OUT,
	// decoded settings
	output sjcd_pkg::sjcd_cfg_s        CFG_OUT,
	output logic                       CFG_VALID_OUT,
	output logic                       CSUM_OK_OUT,
	output logic                       FACT_MISMATCH_OUT,
	output logic                       BUS_INIT_EN_OUT,
	output logic [2:0]                 BUS_ID_OUT,
	output logic                       SPINDLE_ON_OUT
);
	import sjcd_pkg::*;

	localparam int unsigned TICK_W    = $clog2(DLY_UNIT_CYC + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(DLY_UNIT_CYC - 1);

	typedef struct packed {
		sjcd_state_e                     st;
		logic [5:0]                      addr;
		logic                            start;
		logic [7:0]                      sum;
		logic [`SJCD_AREA_LEN-1:0][7:0]  area;
		logic [TICK_W-1:0]               tick;
		logic [7:0]                      units;
		logic [2:0]                      jmp_meta;
		logic [2:0]                      jmp_sync;
		logic                            spin_req;
		sjcd_cfg_s                       cfg;
		logic                            valid;
		logic                            csum_ok;
		logic                            mism;
		logic                            bus_init;
		logic [2:0]                      bus_id;
		logic                            spin_on;
	} sjcd_top_s;

	sjcd_top_s s_q;
	sjcd_top_s s_d;

	logic        ser_done;
	logic [15:0] ser_data;
	logic [7:0]  word_ba;

	if (DLY_UNIT_CYC < 1) begin : g_bad_unit
		$error("delay unit must be at least one cycle");
	end

	// ************************************************
	// helpers
	// ************************************************

	// byte of the captured soft jumper area by image byte offset
	function automatic sjcd_byte_t area_byte(
		input logic [`SJCD_AREA_LEN-1:0][7:0] area,
		input logic [7:0]                     off
	);
		logic [7:0] idx;
		idx = off - `SJCD_CTRL_LOW;
		return area[idx[3:0]];
	endfunction

	// two-of-three vote
	function automatic logic vote3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	// ************************************************
	// serial reader and image store
	// ************************************************
	sjcd_serial_rd #(
		.SK_HALF  (SK_HALF)
	) u_rd (
		.clk_in   (REF_CLK_IN),
		.rst_in   (RST_IN),
		.start_in (s_q.start),
		.addr_in  (s_q.addr),
		.done_out (ser_done),
		.data_out (ser_data),
		.ee_out   (EE_PINS_OUT),
		.ee_do_in (EE_DO_IN)
	);

	sjcd_image_mem #(
		.DEPTH     (`SJCD_WORDS),
		.WIDTH     (`SJCD_WORD_W)
	) u_mem (
		.clk_in    (REF_CLK_IN),
		.rst_in    (RST_IN),
		.we_in     (ser_done),
		.waddr_in  (s_q.addr),
		.wdata_in  (ser_data),
		.raddr_in  (IMG_ADDR_IN),
		.rdata_out (IMG_DATA_OUT)
	);

	// byte offset of the word now arriving
	assign word_ba = {1'b0, s_q.addr, 1'b0};

	// ************************************************
	// loader, decoder and spindle sequencing
	// ************************************************
	always_comb begin
		sjcd_cfg_s  c;
		sjcd_byte_t ctrl_lo;
		sjcd_byte_t fp;
		sjcd_byte_t fa;
		sjcd_byte_t fb;
		sjcd_byte_t ctrl_hi;
		sjcd_byte_t pu;
		sjcd_byte_t sid;
		sjcd_byte_t cust;
		logic [3:0] ai;
		logic       ok;
		c       = '0;
		ctrl_hi = '0;
		pu      = '0;
		sid     = '0;
		cust    = '0;
		ctrl_lo = '0;
		fp      = '0;
		fa      = '0;
		fb      = '0;
		ai      = '0;
		ok      = 1'b0;
		s_d          = s_q;
		s_d.start    = 1'b0;
		s_d.jmp_meta = JUMPER_ID_IN;
		s_d.jmp_sync = s_q.jmp_meta;
		// a command arriving while it is consumed is kept
		s_d.spin_req = s_q.spin_req | SPIN_CMD_IN;

		case (s_q.st)
			ST_LOAD_REQ: begin
				s_d.start = 1'b1;
				s_d.st    = ST_LOAD_WAIT;
			end
			ST_LOAD_WAIT: begin
				if (ser_done) begin
					// sum every byte up to and including the checksum
					if (word_ba < `SJCD_CSUM) begin
						s_d.sum = s_q.sum + ser_data[7:0] + ser_data[15:8];
					end
					// keep a copy of the soft jumper area
					if (word_ba >= `SJCD_CTRL_LOW && word_ba < `SJCD_CSUM) begin
						ai                = 4'(word_ba - `SJCD_CTRL_LOW);
						s_d.area[ai]      = ser_data[7:0];
						s_d.area[ai + 1'b1] = ser_data[15:8];
					end
					if (s_q.addr == 6'(`SJCD_WORDS - 1)) begin
						s_d.st = ST_CHECK;
					end else begin
						s_d.addr = s_q.addr + 6'h01;
						s_d.st   = ST_LOAD_REQ;
					end
				end
			end
			ST_CHECK: begin
				// a sum other than zero throws the whole image away
				ok = (s_q.sum == 8'h00);
				c.heads_per_cylinder = `SJCD_DEF_HEADS;
				if (ok) begin
					// bits 4..7 of the low control byte are never read
					ctrl_lo = area_byte(s_q.area, `SJCD_CTRL_LOW);
					c.wait_spin_enable      = ctrl_lo[`SJCD_WS_BIT];
					c.parity_check_disable  = ctrl_lo[`SJCD_DPC_BIT];
					c.self_seek_enable      = ctrl_lo[`SJCD_SS_BIT];
					c.delayed_spinup_enable = ctrl_lo[`SJCD_DLY_BIT];
					// pull-up slew bits 0..3 carry nothing and are skipped
					ctrl_hi = area_byte(s_q.area, `SJCD_CTRL_HIGH);
					pu      = area_byte(s_q.area, `SJCD_PULLUP);
					c.ack_glitch_filter_enable = ctrl_hi[`SJCD_ACK_BIT];
					c.data_active_negation     = pu[`SJCD_DAPU_BIT];
					c.req_active_negation      = pu[`SJCD_RAPU_BIT];
					fp = area_byte(s_q.area, `SJCD_FACT_PRI);
					fa = area_byte(s_q.area, `SJCD_FACT_BKA);
					fb = area_byte(s_q.area, `SJCD_FACT_BKB);
					// primary outvoted when both backups disagree with it
					c.factory_config_mode = vote3(fp[`SJCD_FACT_BIT],
						fa[`SJCD_FACT_BIT], fb[`SJCD_FACT_BIT]);
					sid  = area_byte(s_q.area, `SJCD_SOFT_ID);
					cust = area_byte(s_q.area, `SJCD_CUST);
					c.soft_id_select = sid[`SJCD_SOFT_ID_SELECT_BIT];
					c.soft_bus_id    = sid[2:0];
					c.heads_per_cylinder = area_byte(s_q.area, `SJCD_HEADS);
					// only the three profile bits carry meaning
					c.customer_profile = cust[2:0];
					c.spinup_delay_count = area_byte(s_q.area, `SJCD_SPIN_DLY);
					c.auto_config_inhibit = area_byte(s_q.area, `SJCD_AUTO_INH);
				end
				s_d.cfg     = c;
				s_d.valid   = 1'b1;
				s_d.csum_ok = ok;
				s_d.mism    = ok && (fp != fa || fp != fb);
				s_d.units   = c.spinup_delay_count;
				s_d.tick    = '0;
				if (s_q.spin_on) begin
					s_d.st = ST_RUN;
				end else if (c.wait_spin_enable) begin
					s_d.st = ST_WAIT_SPIN;
				end else if (c.delayed_spinup_enable) begin
					s_d.st = ST_SPIN_DLY;
				end else begin
					s_d.st = ST_RUN;
				end
			end
			ST_WAIT_SPIN: begin
				if (s_q.spin_req) begin
					s_d.spin_req = SPIN_CMD_IN;
					s_d.st = s_q.cfg.delayed_spinup_enable ? ST_SPIN_DLY : ST_RUN;
				end
			end
			ST_SPIN_DLY: begin
				// count only applies on this path
				// one unit spans DLY_UNIT_CYC cycles; a zero count starts at once
				if (s_q.units == 8'h00) begin
					s_d.st = ST_RUN;
				end else if (s_q.tick == TICK_LAST) begin
					s_d.tick  = '0;
					s_d.units = s_q.units - 8'h01;
				end else begin
					s_d.tick = s_q.tick + 1'b1;
				end
			end
			ST_RUN: begin
				s_d.spin_on = 1'b1;
			end
			default: begin
				s_d.st = ST_LOAD_REQ;
			end
		endcase

		// reload only from run or spin wait, not during the delay; running spindle is left running
		// a reload mid-load is refused so no half-read image decodes
		if (RELOAD_IN && (s_q.st == ST_RUN || s_q.st == ST_WAIT_SPIN)) begin
			s_d.st    = ST_LOAD_REQ;
			s_d.addr  = '0;
			s_d.sum   = '0;
			s_d.valid = 1'b0;
		end

		// bus id source and bus start-up gate
		// jumpers pass the two-flop synchroniser before use
		s_d.bus_id = (s_d.valid && s_d.cfg.soft_id_select) ? s_d.cfg.soft_bus_id
			: s_q.jmp_sync;
		s_d.bus_init = s_d.valid && !s_d.cfg.factory_config_mode;
	end

	// state register
	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s_q    <= '0;
			s_q.st <= ST_LOAD_REQ;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign CFG_OUT           = s_q.cfg;
	assign CFG_VALID_OUT     = s_q.valid;
	assign CSUM_OK_OUT       = s_q.csum_ok;
	assign FACT_MISMATCH_OUT = s_q.mism;
	assign BUS_INIT_EN_OUT   = s_q.bus_init;
	assign BUS_ID_OUT        = s_q.bus_id;
	assign SPINDLE_ON_OUT    = s_q.spin_on;
endmodule // sjcd_top

// ### tb/sjcd_ee_model.sv
`timescale 1ns/100ps

// ************************************************
// serial configuration memory, 64 words of 16 bits
// ************************************************
module sjcd_ee_model (
	// memory pins
	input  wire logic cs_in,
	input  wire logic sk_in,
	input  wire logic di_in,
	output logic      do_out
);
	logic [15:0] mem [64];  // image, filled by the bench
	logic [15:0] sh;
	logic [5:0]  addr;
	logic [5:0]  next_a   = 6'h00;
	logic        order_ok = 1'h1;
	int          bit_n    = 0;
	int          n_words  = 0;
	int          lag_ns   = 0;  // answer delay after sk rise

	initial do_out = 1'h0;

	// released line has no pull-up: show the inverse of the last bit
	always @(negedge cs_in) do_out <= #(lag_ns) ~do_out;

	// bit count restarts with every frame
	always @(posedge cs_in) bit_n = 0;

	// take command and address, answer the word msb first
	always @(posedge sk_in) begin
		if (cs_in) begin
			if (bit_n < 3 && di_in !== (bit_n < 2))
				order_ok = 1'h0;
			if (bit_n >= 3 && bit_n <= 8)
				addr = {addr[4:0], di_in};
			if (bit_n == 8) begin
				if (addr !== next_a)
					order_ok = 1'h0;
				next_a = next_a + 6'h01;
				sh = mem[addr];
				do_out <= #(lag_ns) 1'h0;
			end
			if (bit_n >= 9 && bit_n <= 24)
				do_out <= #(lag_ns) sh[24 - bit_n];
			if (bit_n == 24)
				n_words++;
			bit_n++;
		end
	end
endmodule // sjcd_ee_model

// ### tb/sjcd_props.sv
`timescale 1ns/100ps

// ************************************************
// port checks of the soft jumper decoder
// ************************************************
module sjcd_props #(
	parameter int unsigned DLY_UNIT_CYC = 100000,
	parameter int unsigned SK_HALF      = 5
) (
	// clock and reset
	input wire logic                  REF_CLK_IN,
	input wire logic                  RST_IN,
	// memory pins, board jumpers and firmware inputs
	input wire sjcd_pkg::sjcd_ee_pins_s EE_PINS_OUT,
	input wire logic [2:0]            JUMPER_ID_IN,
	input wire logic                  SPIN_CMD_IN,
	input wire logic                  RELOAD_IN,
	// decoded outputs
	input wire sjcd_pkg::sjcd_cfg_s   CFG_OUT,
	input wire logic                  CFG_VALID_OUT,
	input wire logic                  CSUM_OK_OUT,
	input wire logic                  FACT_MISMATCH_OUT,
	input wire logic                  BUS_INIT_EN_OUT,
	input wire logic [2:0]            BUS_ID_OUT,
	input wire logic                  SPINDLE_ON_OUT
);
	import sjcd_pkg::*;
	logic spin_seen_q;

	// remembers any spin command since reset
	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			spin_seen_q <= 1'h0;
		else if (SPIN_CMD_IN)
			spin_seen_q <= 1'h1;
	end

	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RST_IN);

	// frame and decode relations
	frame_start_a: assert property ($rose(EE_PINS_OUT.cs)
		|-> EE_PINS_OUT.di && !EE_PINS_OUT.sk)
		else $error("frame does not open with start bit");
	sk_idle_a: assert property (!EE_PINS_OUT.cs |-> !EE_PINS_OUT.sk)
		else $error("serial clock runs outside a frame");
	valid_hold_a: assert property ((CFG_VALID_OUT && !RELOAD_IN) [*3]
		|=> CFG_VALID_OUT)
		else $error("settings lost without reload");
	wait_spin_a: assert property ($rose(SPINDLE_ON_OUT) && CFG_OUT.wait_spin_enable
		|-> spin_seen_q)
		else $error("spindle started without spin command");
	spin_sticky_a: assert property (SPINDLE_ON_OUT |=> SPINDLE_ON_OUT)
		else $error("spindle dropped");
	bus_init_a: assert property (BUS_INIT_EN_OUT
		== (CFG_VALID_OUT && !CFG_OUT.factory_config_mode))
		else $error("bus start-up gate wrong");
	fact_cross_a: assert property (FACT_MISMATCH_OUT |-> CSUM_OK_OUT && CFG_VALID_OUT)
		else $error("backup mismatch without good image");
	soft_id_a: assert property (CFG_VALID_OUT && CFG_OUT.soft_id_select
		|-> BUS_ID_OUT == CFG_OUT.soft_bus_id)
		else $error("soft id not used");
	jumper_id_a: assert property (
		($stable(JUMPER_ID_IN) && !(CFG_VALID_OUT && CFG_OUT.soft_id_select)) [*5]
		|-> BUS_ID_OUT == JUMPER_ID_IN)
		else $error("jumper id not used");
	csum_default_a: assert property (CFG_VALID_OUT && !CSUM_OK_OUT
		|-> CFG_OUT.heads_per_cylinder == 8'h01
		&& !CFG_OUT.soft_id_select && !CFG_OUT.factory_config_mode)
		else $error("bad image not replaced by defaults");
	spin_after_a: assert property ($rose(SPINDLE_ON_OUT) |-> CFG_VALID_OUT)
		else $error("spindle before decode");

	// main scenarios
	good_c: cover property ($rose(CFG_VALID_OUT) && CSUM_OK_OUT);
	bad_c: cover property ($rose(CFG_VALID_OUT) && !CSUM_OK_OUT);
	spin_c: cover property ($rose(SPINDLE_ON_OUT) && CFG_OUT.delayed_spinup_enable);
endmodule // sjcd_props

bind sjcd_top sjcd_props #(.DLY_UNIT_CYC(DLY_UNIT_CYC), .SK_HALF(SK_HALF)) sjcd_props_i (
	.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .EE_PINS_OUT(EE_PINS_OUT),
	.JUMPER_ID_IN(JUMPER_ID_IN), .SPIN_CMD_IN(SPIN_CMD_IN), .RELOAD_IN(RELOAD_IN),
	.CFG_OUT(CFG_OUT), .CFG_VALID_OUT(CFG_VALID_OUT), .CSUM_OK_OUT(CSUM_OK_OUT),
	.FACT_MISMATCH_OUT(FACT_MISMATCH_OUT), .BUS_INIT_EN_OUT(BUS_INIT_EN_OUT),
	.BUS_ID_OUT(BUS_ID_OUT), .SPINDLE_ON_OUT(SPINDLE_ON_OUT)
);

// ### tb/sjcd_top_test.sv
`timescale 1ns/100ps

module sjcd_top_test;
	import sjcd_pkg::*;
	localparam int UNIT = 10;
	logic          clk, rst, ee_do, spin, reload;
	logic          valid, csum_ok, mism, bus_init, spindle;
	logic [2:0]    jumper, bus_id;
	logic [5:0]    addr;
	logic [15:0]   img_data;
	logic [7:0]    img [128];
	sjcd_ee_pins_s ee;
	sjcd_cfg_s     cfg;
	int            bad_count  = 0;
	int            n_compared = 0;
	int            cycles     = 0;

	// ************************************************
	// design and memory model
	// ************************************************
	sjcd_top #(.DLY_UNIT_CYC(UNIT)) sjcd_top_i (
		.REF_CLK_IN(clk), .RST_IN(rst), .EE_PINS_OUT(ee), .EE_DO_IN(ee_do),
		.JUMPER_ID_IN(jumper), .SPIN_CMD_IN(spin), .RELOAD_IN(reload),
		.IMG_ADDR_IN(addr), .IMG_DATA_OUT(img_data), .CFG_OUT(cfg), .CFG_VALID_OUT(valid),
		.CSUM_OK_OUT(csum_ok), .FACT_MISMATCH_OUT(mism), .BUS_INIT_EN_OUT(bus_init),
		.BUS_ID_OUT(bus_id), .SPINDLE_ON_OUT(spindle)
	);
	sjcd_ee_model sjcd_ee_model_i (.cs_in(ee.cs), .sk_in(ee.sk), .di_in(ee.di), .do_out(ee_do));

	// clock and hang guard
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			bad_count++;
			$display("unexpected at %0t: run too long", $time);
			tally_and_finish();
		end
	end

	// ************************************************
	// shared tasks
	// ************************************************
	task automatic chk(input logic [38:0] seen, input logic [38:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask

	// image: filler, then soft jumper bytes 48..58, then checksum
	task automatic mk(input logic [87:0] a, input logic bad);
		logic [7:0] sum;
		sum = 8'h00;
		for (int i = 0; i < 59; i++) begin
			img[i] = (i < 48) ? 8'(i) : a[8*(i-48)+:8];
			sum = sum + img[i];
		end
		img[59] = 8'h00 - sum + {7'h00, bad};
		for (int i = 60; i < 128; i++)
			img[i] = 8'h00;
		for (int n = 0; n < 64; n++)
			sjcd_ee_model_i.mem[n] = {img[2*n+1], img[2*n]};
	endtask

	task automatic wait_valid(input logic lvl);
		int n;
		n = 0;
		while (valid !== lvl && n < 20000) begin
			tick(1);
			n++;
		end
		chk(39'(valid), 39'(lvl), "decode state");
	endtask

	task automatic do_reset();
		rst = 1'h1;
		tick(12);
		rst = 1'h0;
	endtask

	task automatic do_reload();
		reload = 1'h1;
		tick(1);
		reload = 1'h0;
		wait_valid(1'h0);
		wait_valid(1'h1);
	endtask

	task automatic wait_on(input int lim, output int n);
		n = 0;
		while (spindle !== 1'h1 && n < lim) begin
			tick(1);
			n++;
		end
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_soft_id();
		int wl [3] = '{5, 24, 27};
		int n;
		mk(88'hA5_0003_060D_0000_0010_01F6, 1'h0);
		do_reset();
		wait_valid(1'h1);
		chk(cfg, {9'h0D9, 3'h5, 8'h06, 3'h3, 8'h00, 8'hA5}, "settings");
		chk(39'(csum_ok), 39'(1'h1), "checksum");
		chk(39'(bus_id), 39'(3'h5), "soft id");
		chk(39'(bus_init), 39'(1'h1), "bus start-up");
		chk(39'(mism), 39'(1'h0), "backup check");
		for (int k = 0; k < 3; k++) begin
			addr = 6'(wl[k]);
			tick(2);
			chk(39'(img_data), 39'({img[2*wl[k]+1], img[2*wl[k]]}), "readback");
		end
		chk(39'(sjcd_ee_model_i.n_words), 39'(64), "word count");
		chk(39'(sjcd_ee_model_i.order_ok), 39'(1'h1), "read order");
		wait_on(10, n);
		chk(39'(spindle), 39'(1'h1), "spindle start");
		$display("test soft_id done");
	endtask

	task automatic t_factory();
		mk(88'h00_0007_0200_0001_0120_0000, 1'h0);
		do_reload();
		chk(cfg, {9'h006, 3'h0, 8'h02, 3'h7, 8'h00, 8'h00}, "settings");
		chk(39'(bus_init), 39'(1'h0), "bus start-up");
		chk(39'(mism), 39'(1'h1), "backup check");
		chk(39'(bus_id), 39'(jumper), "jumper id");
		$display("test factory done");
	endtask

	task automatic t_spin();
		int n;
		mk(88'h00_0300_0400_0000_0000_0009, 1'h0);
		sjcd_ee_model_i.lag_ns = 150;
		do_reset();
		wait_valid(1'h1);
		chk(cfg, {9'h120, 3'h0, 8'h04, 3'h0, 8'h03, 8'h00}, "settings");
		tick(20);
		chk(39'(spindle), 39'(1'h0), "spindle held");
		spin = 1'h1;
		tick(1);
		spin = 1'h0;
		wait_on(60, n);
		chk(39'(n >= 3 * UNIT && n <= 3 * UNIT + 15), 39'(1'h1), "spin-up delay");
		$display("test spin done");
	endtask

	task automatic t_bad_csum();
		mk(88'hA5_0003_060D_0000_0010_01F6, 1'h1);
		jumper = 3'h6;
		do_reload();
		chk(39'(csum_ok), 39'(1'h0), "checksum");
		chk(cfg, {9'h000, 3'h0, 8'h01, 3'h0, 8'h00, 8'h00}, "defaults");
		tick(4);
		chk(39'(bus_id), 39'(3'h6), "jumper id");
		chk(39'(spindle), 39'(1'h1), "spindle kept");
		chk(39'(sjcd_ee_model_i.n_words), 39'(256), "word count");
		chk(39'(sjcd_ee_model_i.order_ok), 39'(1'h1), "read order");
		$display("test bad_csum done");
	endtask

	task automatic tally_and_finish();
		$display("compared %0d, mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		rst = 1'h1;
		spin = 1'h0;
		reload = 1'h0;
		jumper = 3'h2;
		addr = 6'h00;
		t_soft_id();
		t_factory();
		t_spin();
		t_bad_csum();
		tally_and_finish();
	end
endmodule // sjcd_top_test
